// >>> rtl/torp_params.svh
`ifndef TORP_PARAMS_SVH
`define TORP_PARAMS_SVH

// ----------------------------------------------------------------
// Channel and pin layout
// ----------------------------------------------------------------
`define TORP_NUM_CH      3'h5
`define TORP_PWM_SHARED_CYCLE_MODE_LAST   3'h2
`define TORP_PCM_FIRST   3'h1
`define TORP_PCM_LAST    3'h2
`define TORP_COMPLEMENTARY_PWM_MODE_FIRST  3'h3
`define TORP_PIN_A       0
`define TORP_PIN_B       1
`define TORP_PIN_C       2
`define TORP_PIN_D       3

// ----------------------------------------------------------------
// Mode codes, Gray along normal, pwm_single_pair_mode, pwm_shared_cycle_mode, pcm, complementary_pwm_mode, reset_sync_pwm_mode
// ----------------------------------------------------------------
`define TORP_MODE_NORMAL 3'h0
`define TORP_MODE_PWM_SINGLE_PAIR_MODE   3'h1
`define TORP_MODE_PWM_SHARED_CYCLE_MODE   3'h3
`define TORP_MODE_PCM    3'h2
`define TORP_MODE_COMPLEMENTARY_PWM_MODE   3'h6
`define TORP_MODE_RESET_SYNC_PWM_MODE   3'h7

// ----------------------------------------------------------------
// Pin I/O control field, four bits per pin
// ----------------------------------------------------------------
`define TORP_IOC_EN      3
`define TORP_IOC_INIT    2
`define TORP_IOC_RESET   16'h0000
`define TORP_ACT_NONE    2'h0
`define TORP_ACT_LOW     2'h1
`define TORP_ACT_HIGH    2'h2
`define TORP_ACT_TOGGLE  2'h3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TORP_COUNT_RESET 16'h0000
`define TORP_CMP_RESET   16'hffff
`define TORP_LEVEL_RESET 4'h0

`endif

// >>> rtl/torp_pkg.sv
`include "torp_params.svh"

package torp_pkg;

    typedef enum logic [2:0] {
        TORP_NORMAL = `TORP_MODE_NORMAL,
        TORP_PWM_SINGLE_PAIR_MODE   = `TORP_MODE_PWM_SINGLE_PAIR_MODE,
        TORP_PWM_SHARED_CYCLE_MODE   = `TORP_MODE_PWM_SHARED_CYCLE_MODE,
        TORP_PCM    = `TORP_MODE_PCM,
        TORP_COMPLEMENTARY_PWM_MODE   = `TORP_MODE_COMPLEMENTARY_PWM_MODE,
        TORP_RESET_SYNC_PWM_MODE   = `TORP_MODE_RESET_SYNC_PWM_MODE
    } torp_mode_e;

    typedef logic [15:0] torp_word_t;

endpackage

// >>> rtl/torp_chan.sv
`timescale 1ns/1ps
`include "torp_params.svh"

module torp_chan (
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic [2:0]  mode_i,
    input  wire logic [15:0] ioc_i,
    input  wire logic [3:0]  init_i,
    input  wire logic [15:0] init_data_i,
    input  wire logic        run_i,
    input  wire logic        standby_i,
    input  wire logic [3:0]  cmp_wr_i,
    input  wire logic [15:0] cmp_data_i,
    input  wire logic        olsp_i,
    input  wire logic        olsn_i,
    input  wire logic        cyclic_i,
    output logic      [3:0]  level_o,
    output logic      [15:0] count_o,
    output logic      [3:0]  match_o
);

    // ----------------------------------------------------------------
    // Compare and count
    // ----------------------------------------------------------------
    torp_pkg::torp_word_t cmp [4];
    logic [15:0]          next_count;
    logic [3:0]           next_level;
    logic                 pos_on;
    logic                 neg_on;

    wire mode_pwm_single_pair_mode  = (mode_i == `TORP_MODE_PWM_SINGLE_PAIR_MODE);
    wire mode_pwm_shared_cycle_mode  = (mode_i == `TORP_MODE_PWM_SHARED_CYCLE_MODE);
    wire mode_cmpl  = (mode_i == `TORP_MODE_COMPLEMENTARY_PWM_MODE) || (mode_i == `TORP_MODE_RESET_SYNC_PWM_MODE);
    wire cyc_clear  = match_o[`TORP_PIN_A] && (mode_pwm_single_pair_mode || mode_pwm_shared_cycle_mode);

    assign match_o[0] = run_i && (count_o == cmp[0]);
    assign match_o[1] = run_i && (count_o == cmp[1]);
    assign match_o[2] = run_i && (count_o == cmp[2]);
    assign match_o[3] = run_i && (count_o == cmp[3]);

    // Halted counter keeps its value
    assign next_count = !run_i ? count_o : (cyc_clear ? `TORP_COUNT_RESET : count_o + 16'h0001); // [R20]

    function automatic logic apply_act(input logic [1:0] act, input logic cur);
        logic res;
        res = cur;
        if (act == `TORP_ACT_LOW) res = 1'b0;
        else if (act == `TORP_ACT_HIGH) res = 1'b1;
        else if (act == `TORP_ACT_TOGGLE) res = ~cur;
        return res;
    endfunction

    // ----------------------------------------------------------------
    // Pin levels
    // ----------------------------------------------------------------
    always_comb begin
        pos_on     = cyclic_i && (count_o < cmp[`TORP_PIN_B]);
        neg_on     = cyclic_i && !(count_o < cmp[`TORP_PIN_B]);
        next_level = level_o;
        if (standby_i) begin
            next_level = `TORP_LEVEL_RESET; // [R19]
        end else if (mode_cmpl) begin
            // Level and cyclic gating come from output level control only
            next_level[`TORP_PIN_A] = pos_on ? olsp_i : ~olsp_i; // [R13] [R16]
            next_level[`TORP_PIN_B] = neg_on ? olsn_i : ~olsn_i; // [R13] [R16]
            next_level[`TORP_PIN_C] = 1'b0;
            next_level[`TORP_PIN_D] = 1'b0;
        end else begin
            for (int j = 0; j < 4; j++) begin
                if (init_i[j]) begin
                    next_level[j] = init_data_i[4*j + `TORP_IOC_INIT]; // [R12]
                end else if (ioc_i[4*j + `TORP_IOC_EN]) begin
                    if (mode_pwm_single_pair_mode) begin
                        // Odd pins carry no waveform, the pair drives the even pin
                        if (j % 2 == 0) begin
                            if (match_o[j]) begin
                                next_level[j] = apply_act(ioc_i[4*j +: 2], level_o[j]); // [R17]
                            end else if (match_o[j+1]) begin
                                next_level[j] = apply_act(ioc_i[4*(j+1) +: 2], level_o[j]);
                            end
                        end
                    end else if (mode_pwm_shared_cycle_mode) begin
                        if (j != `TORP_PIN_A) begin
                            if (match_o[j]) begin
                                next_level[j] = apply_act(ioc_i[4*j +: 2], level_o[j]); // [R17]
                            end else if (match_o[`TORP_PIN_A]) begin
                                next_level[j] = ioc_i[4*j + `TORP_IOC_INIT];
                            end
                        end
                    end else if (match_o[j]) begin
                        next_level[j] = apply_act(ioc_i[4*j +: 2], level_o[j]); // [R17]
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            count_o <= `TORP_COUNT_RESET;
            level_o <= `TORP_LEVEL_RESET; // [R6]
        end else begin
            count_o <= next_count;
            level_o <= next_level;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            for (int k = 0; k < 4; k++) cmp[k] <= `TORP_CMP_RESET;
        end else begin
            for (int k = 0; k < 4; k++) if (cmp_wr_i[k]) cmp[k] <= cmp_data_i;
        end
    end

endmodule

// >>> rtl/torp_top.sv
`timescale 1ns/1ps
`include "torp_params.svh"

// What this block does
// [R1] PWM single-pair mode: I/O control write leaves B and D pin levels alone.
// [R2] PWM shared-cycle mode: I/O control write leaves the cycle pin (A) alone.
// [R3] Normal or shared-cycle mode: buffered C/D pins are not initialized.
// [R4] Single-pair mode: any C/D buffering blocks initialization of pin C.
// [R5] Software initializes such pins in normal mode before entering PWM modes.
// [R6] After reset timer levels are low and pins float until selected.
// [R7] After reset every channel sits in normal mode.
// [R8] Software enables channel 3/4 master output before initializing their pins.
// [R9] Shared-cycle PWM accepted only on channels 0 to 2.
// [R10] Phase counting accepted only on channels 1 and 2.
// [R11] On error software: port output, stop, new mode, init, reselect, restart.
// [R12] Normal, PWM and phase modes take initial pin levels from I/O control.
// [R13] Complementary and reset-sync modes take levels from output level control.
// [R14] Complementary entry order: normal init, clear I/O, disable, level, mode, enable.
// [R15] Software initializes then disables the normal waveform section first.
// [R16] Output level control selects active levels and cyclic output enable.
// [R17] A low-on-match pin goes low when its compare match occurs.
// [R18] Same-mode restart skips the mode write.
// [R19] Timer levels are forced low by reset and during standby.
// [R20] Start bit one counts; zero halts, keeping count and pin levels.
module torp_top (
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic [2:0]  cfg_chan_i,
    input  wire logic        mode_wr_i,
    input  wire logic [2:0]  mode_data_i,
    input  wire logic        ioc_wr_i,
    input  wire logic [15:0] ioc_data_i,
    input  wire logic        cmp_wr_i,
    input  wire logic [1:0]  cmp_sel_i,
    input  wire logic [15:0] cmp_data_i,
    input  wire logic [4:0]  counter_start_bits_i,
    input  wire logic [1:0]  output_master_enable_i,
    input  wire logic [4:0]  buf_mode_c_i,
    input  wire logic [4:0]  buf_mode_d_i,
    input  wire logic        olsp_i,
    input  wire logic        olsn_i,
    input  wire logic        cyclic_en_i,
    input  wire logic        standby_i,
    input  wire logic [4:0]  pfc_timer_sel_i,
    input  wire logic [4:0]  pfc_port_sel_i,
    input  wire logic [19:0] port_level_i,
    output logic      [19:0] pin_o,
    output logic      [19:0] pin_oe_n_o,
    output logic      [14:0] mode_o,
    output logic             mode_reject_o,
    output logic      [19:0] timer_level_o,
    output logic      [79:0] count_o
);

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    torp_pkg::torp_mode_e mode_q [5];
    torp_pkg::torp_word_t ioc_q  [5];
    logic [3:0]           lvl    [5];
    logic [15:0]          cnt    [5];
    logic [3:0]           mtch   [5];
    logic [19:0]          next_pin;
    logic [19:0]          next_oe_n;

    function automatic logic mode_allowed(input logic [2:0] m, input logic [2:0] ch);
        logic ok;
        ok = 1'b0;
        if (m == `TORP_MODE_NORMAL || m == `TORP_MODE_PWM_SINGLE_PAIR_MODE) begin
            ok = 1'b1;
        end else if (m == `TORP_MODE_PWM_SHARED_CYCLE_MODE) begin
            ok = (ch <= `TORP_PWM_SHARED_CYCLE_MODE_LAST); // [R9]
        end else if (m == `TORP_MODE_PCM) begin
            ok = (ch >= `TORP_PCM_FIRST) && (ch <= `TORP_PCM_LAST); // [R10]
        end else if (m == `TORP_MODE_COMPLEMENTARY_PWM_MODE || m == `TORP_MODE_RESET_SYNC_PWM_MODE) begin
            ok = (ch >= `TORP_COMPLEMENTARY_PWM_MODE_FIRST);
        end
        return ok && (ch < `TORP_NUM_CH);
    endfunction

    // Pins that an I/O control write may initialize in a given mode
    function automatic logic [3:0] init_mask(input logic [2:0] m, input logic bc,
                                             input logic bd);
        logic [3:0] msk;
        msk = 4'hf;
        if (m == `TORP_MODE_PWM_SINGLE_PAIR_MODE) begin
            msk[`TORP_PIN_B] = 1'b0; // [R1]
            msk[`TORP_PIN_D] = 1'b0; // [R1]
            if (bc || bd) msk[`TORP_PIN_C] = 1'b0; // [R4]
        end else if (m == `TORP_MODE_PWM_SHARED_CYCLE_MODE) begin
            msk[`TORP_PIN_A] = 1'b0; // [R2]
        end else if (m == `TORP_MODE_COMPLEMENTARY_PWM_MODE || m == `TORP_MODE_RESET_SYNC_PWM_MODE) begin
            msk = 4'h0; // [R13]
        end
        if (m == `TORP_MODE_NORMAL || m == `TORP_MODE_PWM_SHARED_CYCLE_MODE) begin
            if (bc) msk[`TORP_PIN_C] = 1'b0; // [R3]
            if (bd) msk[`TORP_PIN_D] = 1'b0; // [R3]
        end
        return msk;
    endfunction

    wire [4:0] chan_hit   = 5'h01 << cfg_chan_i;
    wire       chan_valid = (cfg_chan_i < `TORP_NUM_CH);
    wire       mode_ok    = mode_allowed(mode_data_i, cfg_chan_i);
    wire [4:0] oe_eff     = {output_master_enable_i, 3'h7};
    wire [3:0] en_bits    = {ioc_data_i[12 + `TORP_IOC_EN], ioc_data_i[8 + `TORP_IOC_EN],
                             ioc_data_i[4 + `TORP_IOC_EN], ioc_data_i[`TORP_IOC_EN]};
    wire [3:0] cmp_hot    = 4'h1 << cmp_sel_i;

    // ----------------------------------------------------------------
    // Configuration storage
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            for (int i = 0; i < 5; i++) begin
                mode_q[i] <= torp_pkg::TORP_NORMAL; // [R7]
                ioc_q[i]  <= `TORP_IOC_RESET;
            end
            mode_reject_o <= 1'b0;
        end else begin
            for (int i = 0; i < 5; i++) begin
                if (mode_wr_i && mode_ok && chan_hit[i]) begin
                    mode_q[i] <= torp_pkg::torp_mode_e'(mode_data_i); // [R9] [R10]
                end
                if (ioc_wr_i && chan_hit[i]) ioc_q[i] <= ioc_data_i;
            end
            // Refused mode writes leave the old mode in place
            mode_reject_o <= mode_wr_i && !mode_ok;
        end
    end

    // ----------------------------------------------------------------
    // Channels
    // ----------------------------------------------------------------
    for (genvar g = 0; g < 5; g++) begin : g_ch
        wire [3:0] init_g = init_mask(mode_q[g], buf_mode_c_i[g], buf_mode_d_i[g])
                            & en_bits & {4{ioc_wr_i && chan_hit[g] && oe_eff[g]}}; // [R12]
        wire [3:0] lvl_on = lvl[g] & {4{oe_eff[g]}};

        torp_chan u_chan (
            .clk_i       (clk_i),
            .resetn_i    (resetn_i),
            .mode_i      (mode_q[g]),
            .ioc_i       (ioc_q[g]),
            .init_i      (init_g),
            .init_data_i (ioc_data_i),
            .run_i       (counter_start_bits_i[g]),
            .standby_i   (standby_i),
            .cmp_wr_i    (cmp_hot & {4{cmp_wr_i && chan_hit[g]}}),
            .cmp_data_i  (cmp_data_i),
            .olsp_i      (olsp_i),
            .olsn_i      (olsn_i),
            .cyclic_i    (cyclic_en_i),
            .level_o     (lvl[g]),
            .count_o     (cnt[g]),
            .match_o     (mtch[g])
        );

        // Pins float until the pin function controller picks timer or port
        assign next_pin[4*g +: 4]  = pfc_timer_sel_i[g] ? lvl_on : port_level_i[4*g +: 4];
        assign next_oe_n[4*g +: 4] = {4{!(pfc_timer_sel_i[g] || pfc_port_sel_i[g])}}; // [R6]
        assign timer_level_o[4*g +: 4] = lvl[g];
        assign count_o[16*g +: 16]     = cnt[g];
        assign mode_o[3*g +: 3]        = mode_q[g];
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_o      <= 20'h00000;
            pin_oe_n_o <= 20'hfffff; // [R6]
        end else begin
            pin_o      <= next_pin;
            pin_oe_n_o <= next_oe_n;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic       first_q;
    logic [2:0] chan_q;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            first_q <= 1'b0;
            chan_q  <= 3'h0;
        end else begin
            first_q <= 1'b1;
            chan_q  <= cfg_chan_i;
        end
    end

    wire       sel_run  = chan_valid && counter_start_bits_i[cfg_chan_i];
    wire [2:0] sel_mode = chan_valid ? mode_q[cfg_chan_i] : `TORP_MODE_NORMAL;
    wire       sel_bc   = chan_valid && buf_mode_c_i[cfg_chan_i];
    wire       sel_bd   = chan_valid && buf_mode_d_i[cfg_chan_i];
    wire       sel_oe   = chan_valid && oe_eff[cfg_chan_i];

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_ioc_halted;
        ioc_wr_i && chan_valid && !sel_run && !standby_i;
    endsequence

    sequence s_pin_kept(int p);
        ##1 (lvl[chan_q][p] == $past(lvl[cfg_chan_i][p]));
    endsequence

    a_reset_mode_normal: assert property (!first_q |-> (mode_q[0] == torp_pkg::TORP_NORMAL
        && mode_q[3] == torp_pkg::TORP_NORMAL && mode_q[4] == torp_pkg::TORP_NORMAL)) // [R7]
        else $error("mode not normal after reset");
    a_pwm_shared_cycle_mode_chan_limit: assert property (mode_q[3] != torp_pkg::TORP_PWM_SHARED_CYCLE_MODE
        && mode_q[4] != torp_pkg::TORP_PWM_SHARED_CYCLE_MODE) // [R9]
        else $error("shared-cycle mode on channel 3 or 4");
    a_pcm_chan_limit: assert property (mode_q[0] != torp_pkg::TORP_PCM
        && mode_q[3] != torp_pkg::TORP_PCM && mode_q[4] != torp_pkg::TORP_PCM) // [R10]
        else $error("phase counting on wrong channel");
    a_mode_write_refused: assert property (mode_wr_i && !mode_ok |=> mode_reject_o
        && mode_o == $past(mode_o)) // [R9]
        else $error("illegal mode write took effect");
    a_pwm_single_pair_mode_b_kept: assert property (s_ioc_halted and (sel_mode == `TORP_MODE_PWM_SINGLE_PAIR_MODE)
        |-> s_pin_kept(`TORP_PIN_B)) // [R1]
        else $error("pin B initialized in single-pair mode");
    a_pwm_shared_cycle_mode_cycle_kept: assert property (s_ioc_halted and (sel_mode == `TORP_MODE_PWM_SHARED_CYCLE_MODE)
        |-> s_pin_kept(`TORP_PIN_A)) // [R2]
        else $error("cycle pin initialized in shared-cycle mode");
    a_buf_c_kept: assert property (s_ioc_halted and sel_bc and (sel_mode == `TORP_MODE_NORMAL
        || sel_mode == `TORP_MODE_PWM_SHARED_CYCLE_MODE) |-> s_pin_kept(`TORP_PIN_C)) // [R3]
        else $error("buffered pin C initialized");
    a_pwm_single_pair_mode_c_kept: assert property (s_ioc_halted and (sel_bc || sel_bd)
        and (sel_mode == `TORP_MODE_PWM_SINGLE_PAIR_MODE) |-> s_pin_kept(`TORP_PIN_C)) // [R4]
        else $error("pin C initialized with buffering in single-pair mode");
    a_normal_init_level: assert property (s_ioc_halted and sel_oe and ioc_data_i[`TORP_IOC_EN]
        and (sel_mode == `TORP_MODE_NORMAL) |=> lvl[chan_q][`TORP_PIN_A]
        == $past(ioc_data_i[`TORP_IOC_INIT])) // [R12]
        else $error("pin A not initialized from I/O control");
    a_cyclic_off_level: assert property ((mode_q[3] == torp_pkg::TORP_COMPLEMENTARY_PWM_MODE) && !cyclic_en_i
        && !standby_i |=> lvl[3][`TORP_PIN_A] == !$past(olsp_i)) // [R13] [R16]
        else $error("complementary pin not at inactive level");
    a_match_drives_low: assert property (mtch[0][`TORP_PIN_A] && !standby_i
        && mode_q[0] == torp_pkg::TORP_NORMAL && ioc_q[0][`TORP_IOC_EN]
        && ioc_q[0][1:0] == `TORP_ACT_LOW && !(ioc_wr_i && chan_hit[0])
        |=> !lvl[0][`TORP_PIN_A]) // [R17]
        else $error("pin not low after compare match");
    a_standby_low: assert property (standby_i |=> timer_level_o == 20'h00000 ##1
        (pin_o & {20{1'b1}} & ~{{4{!pfc_timer_sel_i[4]}}, {4{!pfc_timer_sel_i[3]}},
        {4{!pfc_timer_sel_i[2]}}, {4{!pfc_timer_sel_i[1]}}, {4{!pfc_timer_sel_i[0]}}})
        == 20'h00000 || !standby_i || $changed(pfc_timer_sel_i)) // [R19]
        else $error("timer level not low in standby");
    a_pins_float: assert property (!pfc_timer_sel_i[0] && !pfc_port_sel_i[0]
        |=> pin_oe_n_o[3:0] == 4'hf) // [R6]
        else $error("unselected pins driven");
    a_halt_keeps_count: assert property (!counter_start_bits_i[0] |-> (mtch[0] == 4'h0)
        ##1 (cnt[0] == $past(cnt[0]))) // [R20]
        else $error("halted counter moved");

endmodule

// >>> tb/torp_stage_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Power stage seen through the pin function controller
// ----------------------------------------------------------------
// Each gate input has a pull-down, so a floating pin reads low.
// Nothing is inferred from the last driven value once released.
module torp_stage_model (
    input  wire logic [19:0] pin_i,
    input  wire logic [19:0] oe_n_i,
    output logic      [19:0] gate_o
);
    assign gate_o = pin_i & ~oe_n_i;
endmodule

// >>> tb/torp_top_tb.sv
`timescale 1ns/1ps

module torp_top_tb;
    typedef struct packed {
        logic [2:0] ch;
        logic [2:0] mode;
        logic       bc;
        logic       bd;
        logic [3:0] exp;
    } torp_row_s;

    logic        clk_i, resetn_i, mode_wr_i, ioc_wr_i, cmp_wr_i;
    logic        olsp_i, olsn_i, cyclic_en_i, standby_i;
    logic [2:0]  cfg_chan_i, mode_data_i;
    logic [15:0] ioc_data_i, cmp_data_i, cnt;
    logic [1:0]  cmp_sel_i, output_master_enable_i;
    logic [4:0]  counter_start_bits_i, buf_mode_c_i, buf_mode_d_i;
    logic [4:0]  pfc_timer_sel_i, pfc_port_sel_i;
    logic [19:0] port_level_i, pin_o, pin_oe_n_o, timer_level_o, gate;
    logic [14:0] mode_o;
    logic        mode_reject_o, seen;
    logic [79:0] count_o;
    int          mismatches, samples_checked;
    torp_row_s   rows [8];
    logic [5:0]  bad [7];

    torp_top uut (.clk_i(clk_i), .resetn_i(resetn_i), .cfg_chan_i(cfg_chan_i),
        .mode_wr_i(mode_wr_i), .mode_data_i(mode_data_i), .ioc_wr_i(ioc_wr_i),
        .ioc_data_i(ioc_data_i), .cmp_wr_i(cmp_wr_i), .cmp_sel_i(cmp_sel_i),
        .cmp_data_i(cmp_data_i), .counter_start_bits_i(counter_start_bits_i),
        .output_master_enable_i(output_master_enable_i), .buf_mode_c_i(buf_mode_c_i),
        .buf_mode_d_i(buf_mode_d_i), .olsp_i(olsp_i), .olsn_i(olsn_i),
        .cyclic_en_i(cyclic_en_i), .standby_i(standby_i),
        .pfc_timer_sel_i(pfc_timer_sel_i), .pfc_port_sel_i(pfc_port_sel_i),
        .port_level_i(port_level_i), .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o),
        .mode_o(mode_o), .mode_reject_o(mode_reject_o),
        .timer_level_o(timer_level_o), .count_o(count_o));

    torp_stage_model stage (.pin_i(pin_o), .oe_n_i(pin_oe_n_o), .gate_o(gate));

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic complete_run();
        $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("CHECK FAILED t=%0t %s", $time, msg);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // Kind 0 mode, 1 pin I/O control, 2 compare A; one strobe per call
    task automatic cfg(input int k, input logic [2:0] ch, input logic [15:0] d);
        @(posedge clk_i);
        cfg_chan_i  <= ch;
        mode_data_i <= d[2:0];
        ioc_data_i  <= d;
        cmp_data_i  <= d;
        mode_wr_i   <= (k == 0);
        ioc_wr_i    <= (k == 1);
        cmp_wr_i    <= (k == 2);
        @(posedge clk_i);
        mode_wr_i <= 1'b0;
        ioc_wr_i  <= 1'b0;
        cmp_wr_i  <= 1'b0;
    endtask

    // Bounded wait for a low-on-match edge on channel 0 pin A
    task automatic wait_low();
        int n;
        n = 0;
        while (timer_level_o[0] !== 1'b0 && n < 20) begin
            settle(1);
            n++;
        end
        if (timer_level_o[0] !== 1'b0) begin
            mismatches++;
            $display("CHECK FAILED t=%0t no compare match seen", $time);
            complete_run();
        end
    endtask

    task automatic reset_and_check();
        resetn_i <= 1'b0;
        settle(3);
        resetn_i <= 1'b1;
        chk(pin_oe_n_o === 20'hfffff && gate === 20'h00000, "pins not floating");
        chk(timer_level_o === 20'h00000 && count_o === 80'h0, "levels not low");
        chk(mode_o === 15'h0000 && mode_reject_o === 1'b0, "mode not normal");
    endtask

    initial begin
        {mode_wr_i, ioc_wr_i, cmp_wr_i, cyclic_en_i, standby_i, olsn_i} = '0;
        {cfg_chan_i, mode_data_i, ioc_data_i, cmp_data_i, cmp_sel_i} = '0;
        {counter_start_bits_i, buf_mode_c_i, buf_mode_d_i, port_level_i} = '0;
        {pfc_timer_sel_i, pfc_port_sel_i} = '0;
        output_master_enable_i = 2'h3;
        olsp_i = 1'b1;
        resetn_i = 1'b0;
        mismatches = 0;
        samples_checked = 0;
        rows = '{'{3'h0, 3'h0, 1'b0, 1'b0, 4'hf}, '{3'h0, 3'h1, 1'b0, 1'b0, 4'h5},
                 '{3'h0, 3'h1, 1'b0, 1'b1, 4'h1}, '{3'h1, 3'h3, 1'b0, 1'b0, 4'he},
                 '{3'h2, 3'h0, 1'b1, 1'b1, 4'h3}, '{3'h1, 3'h2, 1'b0, 1'b0, 4'hf},
                 '{3'h3, 3'h6, 1'b0, 1'b0, 4'h2}, '{3'h4, 3'h0, 1'b0, 1'b0, 4'hf}};
        bad = '{{3'h3, 3'h3}, {3'h0, 3'h2}, {3'h4, 3'h2}, {3'h0, 3'h6},
                {3'h2, 3'h7}, {3'h5, 3'h0}, {3'h1, 3'h4}};
        reset_and_check();
        // ----------------------------------------------------------------
        // Table rows: init low in normal mode, switch mode, init high
        // ----------------------------------------------------------------
        foreach (rows[i]) begin
            buf_mode_c_i <= 5'h00;
            buf_mode_d_i <= 5'h00;
            cfg(0, rows[i].ch, 16'h0000);
            cfg(1, rows[i].ch, 16'h8888);
            if (rows[i].mode == 3'h6) begin
                cfg(1, rows[i].ch, 16'h0000);
                output_master_enable_i <= 2'h0;
            end
            buf_mode_c_i[rows[i].ch] <= rows[i].bc;
            buf_mode_d_i[rows[i].ch] <= rows[i].bd;
            cfg(0, rows[i].ch, {13'h0000, rows[i].mode});
            output_master_enable_i <= 2'h3;
            cfg(1, rows[i].ch, 16'hcccc);
            settle(1);
            chk(mode_o[3*rows[i].ch +: 3] === rows[i].mode, "mode not stored");
            chk(timer_level_o[4*rows[i].ch +: 4] === rows[i].exp, "bad init");
        end
        buf_mode_c_i <= 5'h00;
        buf_mode_d_i <= 5'h00;
        // ----------------------------------------------------------------
        // Refused mode writes
        // ----------------------------------------------------------------
        foreach (bad[i]) begin
            cfg(0, bad[i][5:3], {13'h0000, bad[i][2:0]});
            seen = 1'b0;
            repeat (2) begin
                #1 seen = seen | (mode_reject_o === 1'b1);
                @(posedge clk_i);
            end
            chk(seen, "mode write not refused");
        end
        // ----------------------------------------------------------------
        // Match, error cutoff, stop, same-mode restart
        // ----------------------------------------------------------------
        cfg(0, 3'h0, 16'h0000);
        cfg(2, 3'h0, 16'h0003);
        cfg(1, 3'h0, 16'h000d);
        pfc_timer_sel_i <= 5'h01;
        settle(2);
        chk(pin_o[0] === 1'b1 && gate[0] === 1'b1, "initial high not on pin");
        counter_start_bits_i <= 5'h01;
        wait_low();
        chk(count_o[15:0] === 16'h0004, "match level at wrong count");
        pfc_timer_sel_i <= 5'h00;
        pfc_port_sel_i  <= 5'h01;
        port_level_i    <= 20'h00001;
        settle(2);
        chk(pin_o[0] === 1'b1 && pin_oe_n_o[0] === 1'b0, "port output not shown");
        counter_start_bits_i <= 5'h00;
        settle(1);
        cnt = count_o[15:0];
        settle(3);
        chk(count_o[15:0] === cnt && timer_level_o[0] === 1'b0, "halt lost state");
        cfg(2, 3'h0, cnt + 16'h0003);
        cfg(1, 3'h0, 16'h000d);
        settle(1);
        chk(timer_level_o[0] === 1'b1, "reinit failed");
        pfc_port_sel_i  <= 5'h00;
        pfc_timer_sel_i <= 5'h01;
        counter_start_bits_i <= 5'h01;
        wait_low();
        chk(count_o[15:0] === cnt + 16'h0004, "restart match wrong");
        // ----------------------------------------------------------------
        // Standby and reset in mid-run
        // ----------------------------------------------------------------
        cfg(1, 3'h0, 16'h000c);
        standby_i <= 1'b1;
        settle(2);
        chk(timer_level_o === 20'h00000, "standby left a level high");
        standby_i <= 1'b0;
        reset_and_check();
        complete_run();
    end
endmodule
